// ---- src/sspi_device.sv ----
/*
 * sensor-side serial register port, sampling the link on the system clock.
 * assumes the sensing datapath supplies buffer level and event flags on
 * i_clock, and the link clock is slow enough for three-cycle detection.
 */
// Design decision made here: the serial register port.
`timescale 1ns/1ps
module sspi_device (
   input  wire logic              i_clock,
   input  wire logic              i_rst,
   sspi_link.device               link,
   input  wire logic              i_buf_half,
   input  wire logic              i_buf_three_q,
   input  wire logic              i_free_fall,
   input  wire logic              i_motion,
   input  wire logic              i_sample_tick,
   output logic                   o_event_pin,
   output logic [2:0]             o_buf_axis_en,
   output logic                   o_buf_load,
   output logic                   o_lock_open,
   output logic                   o_frame_fault
);
   import sspi_pkg::*;

   logic [2:0]           sclk_sync;
   logic [2:0]           cs_sync;
   logic [1:0]           mosi_sync;
   logic [BIT_CNT_W-1:0] bit_cnt;
   logic [ADDR_W-1:0]    cmd_addr;
   logic                 cmd_write;
   logic [7:0]           wr_data;
   logic [6:0]           rx_shift;
   logic [7:0]           out_data;
   logic [7:0]           lock_key;
   logic [1:0]           key_stage;
   logic [4:0]           selector;
   logic [7:0]           event_pin_config;
   logic [4:0]           out_cfg;
   logic [7:0]           indirect_write_data;
   logic [1:0]           rate_cnt;
   logic [7:0]           rd_mux;
   logic [7:0]           status;
   logic [7:0]           indirect_rd;
   logic                 sclk_rise;
   logic                 sclk_fall;
   logic                 cs_fall;
   logic                 cs_rise;
   logic                 in_frame;
   logic                 frame_ok;
   logic                 commit;
   logic                 next_bit;
   logic                 ev_active;
   logic                 ev_gated;
   logic                 rate_pass;

   // stage 0 of each synchroniser feeds only stage 1
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         sclk_sync <= 3'h0;
         cs_sync   <= 3'h7;
         mosi_sync <= 2'h0;
      end else begin
         sclk_sync <= {sclk_sync[1:0], link.sclk};
         cs_sync   <= {cs_sync[1:0], link.select_n_line};
         mosi_sync <= {mosi_sync[0], link.mosi};
      end
   end

   assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
   assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
   assign cs_fall   = ~cs_sync[1] & cs_sync[2];
   assign cs_rise   = cs_sync[1] & ~cs_sync[2];
   assign in_frame  = ~cs_sync[1];
   // a frame is good only at sixteen clocks or more and a whole number of bytes
   assign frame_ok  = (bit_cnt >= BIT_CNT_W'(FRAME_BITS)) && (bit_cnt[2:0] == 3'h0);
   assign commit    = cs_rise & frame_ok & cmd_write;

   // bit counter and command capture on rising link clock
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         bit_cnt   <= '0;
         rx_shift  <= 7'h00;
         cmd_addr  <= '0;
         cmd_write <= 1'b0;
         wr_data   <= BYTE_RESET;
      end else if (cs_fall) begin
         bit_cnt   <= '0;
         cmd_write <= 1'b0;
      end else if (in_frame && sclk_rise) begin
         if (bit_cnt != '1) begin
            bit_cnt <= bit_cnt + 1'b1;
         end
         rx_shift <= {rx_shift[5:0], mosi_sync[1]};
         if (bit_cnt == BIT_CNT_W'(ADDR_W - 1)) begin
            cmd_addr <= {rx_shift[4:0], mosi_sync[1]};
         end
         if (bit_cnt == BIT_CNT_W'(ADDR_W)) begin
            cmd_write <= mosi_sync[1];
         end
         if (bit_cnt == BIT_CNT_W'(FRAME_BITS - 1)) begin
            wr_data <= {rx_shift[6:0], mosi_sync[1]};
         end
      end
   end

   // read multiplexer, indirect window through the selector
   always_comb begin
      indirect_rd = BYTE_RESET;
      if (selector == SEL_OUT_CFG) begin
         indirect_rd = {3'b000, out_cfg};
      end
      status = BYTE_RESET;
      status[ST_FAULT_BIT] = o_frame_fault;
      status[ST_LOCK_BIT]  = o_lock_open;
      rd_mux = BYTE_RESET;
      unique case (cmd_addr)
         ADDR_STATUS:    rd_mux = status;
         ADDR_LOCK_KEY:  rd_mux = lock_key;
         ADDR_SELECTOR:  rd_mux = {3'b000, selector};
         ADDR_EVENT_CFG: rd_mux = event_pin_config;
         ADDR_INDIRECT:  rd_mux = indirect_rd;
         default:        rd_mux = BYTE_RESET;
      endcase
   end

   // next outgoing bit, position bit_cnt+1 of the frame
   always_comb begin
      next_bit = 1'b0;
      if (bit_cnt == BIT_CNT_W'(POS_FAULT - 1)) begin
         next_bit = o_frame_fault;
      end else if (bit_cnt == BIT_CNT_W'(POS_ONE - 1)) begin
         next_bit = 1'b1;
      end else if (bit_cnt == BIT_CNT_W'(POS_PARITY - 1)) begin
         next_bit = ~^rd_mux;
      end else if (bit_cnt >= BIT_CNT_W'(POS_PARITY) && bit_cnt < BIT_CNT_W'(FRAME_BITS)) begin
         next_bit = out_data[7];
      end
   end

   // output shift register and data line
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         out_data      <= BYTE_RESET;
         link.miso     <= 1'b0;
         link.miso_oe  <= 1'b0;
      end else begin
         link.miso_oe <= in_frame;
         if (cs_fall) begin
            link.miso <= 1'b0;
         end else if (in_frame && sclk_rise && bit_cnt == BIT_CNT_W'(BYTE_BITS - 1)) begin
            out_data <= rd_mux;
         end else if (in_frame && sclk_fall) begin
            link.miso <= next_bit;
            if (bit_cnt >= BIT_CNT_W'(POS_PARITY)) begin
               out_data <= {out_data[6:0], 1'b0};
            end
         end
      end
   end

   // fault flag follows every ended frame
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_frame_fault <= 1'b0;
      end else if (cs_rise) begin
         o_frame_fault <= ~frame_ok;
      end
   end

   // register writes land only when select rises on a good frame
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         selector            <= SEL_RESET;
         event_pin_config    <= EV_CFG_RESET;
         out_cfg             <= OUT_CFG_RESET;
         indirect_write_data <= BYTE_RESET;
      end else if (commit) begin
         if (cmd_addr == ADDR_SELECTOR) begin
            selector <= wr_data[4:0];
         end
         if (cmd_addr == ADDR_EVENT_CFG) begin
            event_pin_config <= wr_data & EV_CFG_WRITABLE;
         end
         if (cmd_addr == ADDR_INDIRECT && o_lock_open) begin
            indirect_write_data <= wr_data;
            if (selector == SEL_OUT_CFG) begin
               out_cfg <= wr_data[4:0];
            end
         end
      end
   end

   // key tracker: any break in 00h, 50h, a0h closes the lock
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         lock_key    <= BYTE_RESET;
         key_stage   <= 2'd0;
         o_lock_open <= 1'b0;
      end else if (commit && cmd_addr == ADDR_LOCK_KEY) begin
         lock_key    <= wr_data;
         o_lock_open <= 1'b0;
         key_stage   <= 2'd0;
         if (key_stage == 2'd1 && wr_data == KEY_SECOND) begin
            key_stage <= 2'd2;
         end else if (key_stage == 2'd2 && wr_data == KEY_THIRD) begin
            o_lock_open <= 1'b1;
         end else if (wr_data == KEY_FIRST) begin
            key_stage <= 2'd1;
         end
      end
   end

   // event pin: enables, global mask, then polarity
   assign ev_active = (event_pin_config[EV_FULL_BIT] & i_buf_three_q)
                    | (event_pin_config[EV_HALF_BIT] & i_buf_half)
                    | i_free_fall | i_motion;
   assign ev_gated  = ev_active & ~event_pin_config[EV_MASK_BIT];

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_event_pin <= 1'b0;
      end else begin
         o_event_pin <= event_pin_config[EV_POL_BIT] ? ev_gated : ~ev_gated;
      end
   end

   // buffer load thinning; output registers keep full rate elsewhere
   always_comb begin
      rate_pass = 1'b1;
      if (out_cfg[1:0] == RATE_DIV4) begin
         rate_pass = (rate_cnt == 2'd3);
      end else if (out_cfg[1:0] == RATE_DIV2) begin
         rate_pass = rate_cnt[0];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         rate_cnt      <= 2'd0;
         o_buf_load    <= 1'b0;
         o_buf_axis_en <= OUT_CFG_RESET[4:2];
      end else begin
         o_buf_axis_en <= {out_cfg[OUT_X_BIT], out_cfg[OUT_Y_BIT], out_cfg[OUT_Z_BIT]};
         o_buf_load    <= i_sample_tick & rate_pass;
         if (i_sample_tick) begin
            rate_cnt <= rate_cnt + 2'd1;
         end
      end
   end
endmodule

// ---- src/sspi_host.sv ----
/*
 * controller end: apb slave taking one frame order at a time and driving
 * the serial link with a clock divided from i_clock.
 * assumes the sensor port answers on the link as the device end does.
 */
`timescale 1ns/1ps
module sspi_host #(
   parameter int HALF = sspi_pkg::HALF_CYC
) (
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   sspi_link.host           link
);
   import sspi_pkg::*;

   // the sensor needs several of its own clocks per link half period
   if (HALF < 4 || HALF > 256) begin : g_half_bad
      $error("HALF outside the range the link timing supports");
   end

   typedef enum logic [2:0] {
      SSPI_IDLE  = 3'b000,
      SSPI_LEAD  = 3'b001,
      SSPI_LOW   = 3'b010,
      SSPI_HIGH  = 3'b011,
      SSPI_TRAIL = 3'b100,
      SSPI_GAP   = 3'b101
   } sspi_state_e;

   sspi_state_e state;
   logic [15:0] tx;
   logic [15:0] rx;
   logic [7:0]  half_cnt;
   logic [3:0]  bit_idx;
   logic [1:0]  miso_sync;
   logic        busy;
   logic        apb_done;
   logic        start;
   logic        tick;

   assign apb_done = i_psel & i_penable & o_pready;
   assign start    = apb_done & i_pwrite & (i_paddr == HOST_CMD) & ~busy;
   assign tick     = (half_cnt == 8'(HALF - 1));

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         miso_sync <= 2'b00;
      end else begin
         miso_sync <= {miso_sync[0], link.miso};
      end
   end

   // one wait state: ready is high in the second access cycle
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0000_0000;
      end else begin
         o_pready  <= i_psel & i_penable & ~o_pready;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         if (i_psel & i_penable & ~o_pready) begin
            o_pslverr <= (i_paddr != HOST_CMD) && (i_paddr != HOST_STATUS);
            if (~i_pwrite && i_paddr == HOST_STATUS) begin
               o_prdata[HST_BUSY_BIT]   <= busy;
               o_prdata[HST_FAULT_BIT]  <= rx[16 - POS_FAULT];
               o_prdata[HST_PAR_OK_BIT] <= rx[16 - POS_PARITY] == ~^rx[7:0];
               o_prdata[HST_DATA_LSB +: 8] <= rx[7:0];
            end else if (~i_pwrite && i_paddr == HOST_CMD) begin
               o_prdata[15:0] <= tx;
            end
         end
      end
   end

   // frame sequencer; a command written while busy is dropped
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state              <= SSPI_IDLE;
         busy               <= 1'b0;
         half_cnt           <= 8'h00;
         bit_idx            <= 4'h0;
         tx                 <= 16'h0000;
         rx                 <= 16'h0000;
         link.sclk          <= 1'b0;
         link.select_n_line <= 1'b1;
         link.mosi          <= 1'b0;
      end else begin
         half_cnt <= tick ? 8'h00 : half_cnt + 8'h01;
         unique case (state)
            SSPI_IDLE: begin
               half_cnt <= 8'h00;
               if (start) begin
                  tx <= {i_pwdata[5:0], i_pwdata[CMD_WRITE_BIT], 1'b0,
                         i_pwdata[CMD_DATA_LSB +: 8]};
                  busy               <= 1'b1;
                  bit_idx            <= 4'h0;
                  link.select_n_line <= 1'b0;
                  link.mosi          <= i_pwdata[5];
                  state              <= SSPI_LEAD;
               end
            end
            SSPI_LEAD, SSPI_LOW: begin
               if (tick) begin
                  link.sclk <= 1'b1;
                  state     <= SSPI_HIGH;
               end
            end
            SSPI_HIGH: begin
               if (tick) begin
                  rx        <= {rx[14:0], miso_sync[1]};
                  link.sclk <= 1'b0;
                  bit_idx   <= bit_idx + 4'h1;
                  // wraps to bit 15 after the last bit; the sensor never samples it
                  link.mosi <= tx[4'hf - bit_idx - 4'h1];
                  state     <= (bit_idx == 4'hf) ? SSPI_TRAIL : SSPI_LOW;
               end
            end
            SSPI_TRAIL: begin
               if (tick) begin
                  link.select_n_line <= 1'b1;
                  link.mosi          <= 1'b0;
                  state              <= SSPI_GAP;
               end
            end
            SSPI_GAP: begin
               if (tick) begin
                  busy  <= 1'b0;
                  state <= SSPI_IDLE;
               end
            end
            default: state <= SSPI_IDLE;
         endcase
      end
   end
endmodule

// ---- src/sspi_link.sv ----
/*
 * the four-wire serial link between the controller and the sensor port.
 * assumes the bench instantiates it and joins both ends to it.
 */
`timescale 1ns/1ps
interface sspi_link;
   logic sclk;
   logic select_n_line;
   logic mosi;
   logic miso;
   logic miso_oe;

   modport device (input sclk, input select_n_line, input mosi, output miso, output miso_oe);
   modport host (output sclk, output select_n_line, output mosi, input miso, input miso_oe);
endinterface

// ---- src/sspi_pkg.sv ----
/*
 * shared constants for the serial register port: frame layout, register
 * offsets, field positions, reset values and link timing.
 * assumes both ends and the bench import it.
 */
package sspi_pkg;
   localparam int FRAME_BITS    = 16;
   localparam int BYTE_BITS     = 8;
   localparam int ADDR_W        = 6;
   localparam int BIT_CNT_W     = 6;
   // 1-based bit positions inside the first returned byte
   localparam int POS_FAULT     = 2;
   localparam int POS_ONE       = 7;
   localparam int POS_PARITY    = 8;
   // device register offsets
   localparam logic [5:0] ADDR_STATUS    = 6'h02;
   localparam logic [5:0] ADDR_LOCK_KEY  = 6'h1e;
   localparam logic [5:0] ADDR_SELECTOR  = 6'h20;
   localparam logic [5:0] ADDR_EVENT_CFG = 6'h21;
   localparam logic [5:0] ADDR_INDIRECT  = 6'h22;
   // status fields
   localparam int ST_FAULT_BIT   = 0;
   localparam int ST_LOCK_BIT    = 3;
   // key sequence
   localparam logic [7:0] KEY_FIRST  = 8'h00;
   localparam logic [7:0] KEY_SECOND = 8'h50;
   localparam logic [7:0] KEY_THIRD  = 8'ha0;
   // event pin configuration
   localparam int EV_FULL_BIT    = 7;
   localparam int EV_HALF_BIT    = 6;
   localparam int EV_MASK_BIT    = 1;
   localparam int EV_POL_BIT     = 0;
   localparam logic [7:0] EV_CFG_RESET    = 8'h41;
   localparam logic [7:0] EV_CFG_WRITABLE = 8'hc3;
   // indirect output configuration
   localparam logic [4:0] SEL_OUT_CFG     = 5'b01011;
   localparam logic [4:0] SEL_RESET       = 5'h00;
   localparam logic [4:0] OUT_CFG_RESET   = 5'h1c;
   localparam int OUT_X_BIT      = 4;
   localparam int OUT_Y_BIT      = 3;
   localparam int OUT_Z_BIT      = 2;
   localparam logic [1:0] RATE_DIV4 = 2'b10;
   localparam logic [1:0] RATE_DIV2 = 2'b01;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   // host register offsets (byte addresses)
   localparam logic [7:0] HOST_CMD    = 8'h00;
   localparam logic [7:0] HOST_STATUS = 8'h04;
   localparam int CMD_WRITE_BIT   = 6;
   localparam int CMD_DATA_LSB    = 8;
   localparam int HST_BUSY_BIT    = 0;
   localparam int HST_FAULT_BIT   = 1;
   localparam int HST_PAR_OK_BIT  = 2;
   localparam int HST_DATA_LSB    = 8;
   // link timing
   localparam int CLK_PERIOD_NS   = 10;
   localparam int LINK_PERIOD_NS  = 125;
   localparam int HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
endpackage

// ---- testbench/sensor_spi_slave_register_port_tb.sv ----
/*
 * bench: controller and sensor ends joined on one link and driven over apb;
 * a second sensor end is driven by hand to send it short frames.
 * assumes the default link half period of the controller end.
 */
`timescale 1ns/1ps
module sensor_spi_slave_register_port_tb;
   import sspi_pkg::*;
   logic        i_clock = 1'b0;
   logic        i_rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        err_seen;
   logic        buf_half;
   logic        three_q;
   logic        free_fall;
   logic        motion;
   logic        tick;
   logic        event_pin;
   logic [2:0]  axis_en;
   logic        buf_load;
   logic        lock_open;
   logic        frame_fault;
   logic        fault_b;
   int          mismatches = 0;
   int          comparisons = 0;

   always #5 i_clock = ~i_clock;

   sspi_link u_sspi_link ();
   sspi_link u_sspi_link_b ();

   sspi_host u_sspi_host (
      .i_clock   (i_clock),
      .i_rst     (i_rst),
      .i_psel    (psel),
      .i_penable (penable),
      .i_pwrite  (pwrite),
      .i_paddr   (paddr),
      .i_pwdata  (pwdata),
      .o_prdata  (prdata),
      .o_pready  (pready),
      .o_pslverr (pslverr),
      .link      (u_sspi_link)
   );

   sspi_device u_sspi_device (
      .i_clock       (i_clock),
      .i_rst         (i_rst),
      .link          (u_sspi_link),
      .i_buf_half    (buf_half),
      .i_buf_three_q (three_q),
      .i_free_fall   (free_fall),
      .i_motion      (motion),
      .i_sample_tick (tick),
      .o_event_pin   (event_pin),
      .o_buf_axis_en (axis_en),
      .o_buf_load    (buf_load),
      .o_lock_open   (lock_open),
      .o_frame_fault (frame_fault)
   );

   sspi_device u_sspi_device_b (
      .i_clock       (i_clock),
      .i_rst         (i_rst),
      .link          (u_sspi_link_b),
      .i_buf_half    (buf_half),
      .i_buf_three_q (three_q),
      .i_free_fall   (free_fall),
      .i_motion      (motion),
      .i_sample_tick (tick),
      .o_event_pin   (),
      .o_buf_axis_en (),
      .o_buf_load    (),
      .o_lock_open   (),
      .o_frame_fault (fault_b)
   );

   sspi_sva u_sspi_sva (
      .i_clock       (i_clock),
      .i_rst         (i_rst),
      .sclk          (u_sspi_link.sclk),
      .select_n_line (u_sspi_link.select_n_line),
      .mosi          (u_sspi_link.mosi),
      .miso          (u_sspi_link.miso),
      .miso_oe       (u_sspi_link.miso_oe)
   );

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic hang();
      mismatches++;
      summarize();
   endtask

   // entered just after a rising edge; leaves one idle cycle behind it
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clock);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge i_clock);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         hang();
      end
      r = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_clock);
   endtask

   // one frame through the controller end; e is the expected reply byte
   task automatic op(input logic [5:0] a, input logic w, input logic [7:0] d,
                     input logic [7:0] e);
      logic [31:0] st;
      int          k;
      apb(1'b1, HOST_CMD, {16'h0000, d, 1'b0, w, a}, st);
      k = 0;
      do begin
         apb(1'b0, HOST_STATUS, 32'h0000_0000, st);
         k++;
      end while (st[HST_BUSY_BIT] !== 1'b0 && k < 200);
      if (k >= 200) begin
         hang();
      end
      check(st[HST_DATA_LSB+:8], e);
      check(st[HST_PAR_OK_BIT], 1'b1);
      check(st[HST_FAULT_BIT], 1'b0);
      check(frame_fault, 1'b0);
   endtask

   // hand-driven frame of n clocks on the second link, reply msb first
   task automatic bang(input logic [15:0] w, input int n, output logic [15:0] r);
      r = 16'h0000;
      u_sspi_link_b.select_n_line <= 1'b0;
      for (int i = 0; i < n; i++) begin
         u_sspi_link_b.mosi <= w[15-i];
         // alternate 6 and 7 cycle low halves: 125 ns mean period
         repeat (6 + i % 2) @(posedge i_clock);
         u_sspi_link_b.sclk <= 1'b1;
         r = {r[14:0], u_sspi_link_b.miso};
         repeat (6) @(posedge i_clock);
         u_sspi_link_b.sclk <= 1'b0;
      end
      repeat (6) @(posedge i_clock);
      u_sspi_link_b.select_n_line <= 1'b1;
      u_sspi_link_b.mosi <= 1'b0;
      repeat (6) @(posedge i_clock);
   endtask

   task automatic t_reset();
      logic [31:0] st;
      check(axis_en, 3'b111);
      check(lock_open, 1'b0);
      op(ADDR_EVENT_CFG, 1'b0, 8'h00, EV_CFG_RESET);
      op(ADDR_LOCK_KEY, 1'b0, 8'h00, 8'h00);
      op(ADDR_STATUS, 1'b0, 8'h00, 8'h00);
      op(ADDR_INDIRECT, 1'b0, 8'h00, 8'h00);
      apb(1'b0, 8'h08, 32'h0000_0000, st);
      check(err_seen, 1'b1);
   endtask

   task automatic t_write();
      op(ADDR_EVENT_CFG, 1'b1, 8'hff, EV_CFG_RESET);
      op(ADDR_EVENT_CFG, 1'b0, 8'h5a, EV_CFG_WRITABLE);
      op(ADDR_EVENT_CFG, 1'b1, EV_CFG_RESET, EV_CFG_WRITABLE);
   endtask

   // each row: config, {half, three quarter, free fall, motion}, pin level
   task automatic t_pin();
      logic [12:0] pins [7] = '{{8'h41, 5'b10001}, {8'h01, 5'b10000},
         {8'h81, 5'b01001}, {8'h01, 5'b01000}, {8'h83, 5'b11110},
         {8'h80, 5'b01000}, {8'h80, 5'b00001}};
      logic [7:0]  prev = EV_CFG_RESET;
      foreach (pins[i]) begin
         op(ADDR_EVENT_CFG, 1'b1, pins[i][12:5], prev);
         prev = pins[i][12:5];
         {buf_half, three_q, free_fall, motion} <= pins[i][4:1];
         repeat (4) @(posedge i_clock);
         check(event_pin, pins[i][0]);
      end
      {buf_half, three_q, free_fall, motion} <= 4'h0;
   endtask

   task automatic t_indirect();
      logic [1:0] rt [4] = '{RATE_DIV4, RATE_DIV2, 2'b00, 2'b11};
      int         ex [4] = '{2, 4, 8, 8};
      logic [7:0] prev = 8'h0e;
      int         n;
      op(ADDR_SELECTOR, 1'b1, {3'b000, SEL_OUT_CFG}, 8'h00);
      op(ADDR_INDIRECT, 1'b1, 8'h0e, OUT_CFG_RESET);
      op(ADDR_INDIRECT, 1'b0, 8'h00, OUT_CFG_RESET);
      op(ADDR_LOCK_KEY, 1'b1, KEY_FIRST, 8'h00);
      op(ADDR_LOCK_KEY, 1'b1, KEY_SECOND, KEY_FIRST);
      check(lock_open, 1'b0);
      op(ADDR_LOCK_KEY, 1'b1, KEY_THIRD, KEY_SECOND);
      check(lock_open, 1'b1);
      op(ADDR_STATUS, 1'b0, 8'h00, 8'h08);
      op(ADDR_INDIRECT, 1'b1, prev, OUT_CFG_RESET);
      check(axis_en, 3'b011);
      foreach (rt[i]) begin
         op(ADDR_INDIRECT, 1'b1, {6'h07, rt[i]}, prev);
         prev = {6'h07, rt[i]};
         n = 0;
         for (int j = 0; j < 30; j++) begin
            tick <= (j < 24 && j % 3 == 0);
            @(posedge i_clock);
            n = n + int'(buf_load === 1'b1);
         end
         check(n, ex[i]);
      end
      op(ADDR_LOCK_KEY, 1'b1, KEY_SECOND, KEY_THIRD);
      check(lock_open, 1'b0);
      op(ADDR_INDIRECT, 1'b1, 8'h00, prev);
      op(ADDR_INDIRECT, 1'b0, 8'h00, prev);
   endtask

   task automatic t_fault();
      logic [15:0] r;
      int          lens [2] = '{8, 12};
      foreach (lens[i]) begin
         bang({ADDR_EVENT_CFG, 2'b10, 8'h00}, lens[i], r);
         check(fault_b, 1'b1);
         bang({ADDR_EVENT_CFG, 2'b00, 8'h00}, 16, r);
         check(r[14], 1'b1);
         check(r[9], 1'b1);
         check(^r[8:0], 1'b1);
         check(r[7:0], EV_CFG_RESET);
         check(fault_b, 1'b0);
      end
   endtask

   initial begin
      i_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      {buf_half, three_q, free_fall, motion, tick} = 5'h00;
      u_sspi_link_b.sclk = 1'b0;
      u_sspi_link_b.select_n_line = 1'b1;
      u_sspi_link_b.mosi = 1'b0;
      repeat (2) @(posedge i_clock);
      i_rst <= 1'b0;
      @(posedge i_clock);
      t_reset();
      t_write();
      t_pin();
      t_indirect();
      t_fault();
      summarize();
   end
endmodule

// ---- testbench/sspi_sva.sv ----
/*
 * link checker: watches the four serial wires and the data enable between
 * the controller end and the sensor end.
 * assumes the controller end drives the link from flops on i_clock.
 */
`timescale 1ns/1ps
module sspi_sva (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic sclk,
   input wire logic select_n_line,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   logic [4:0]  rises;
   logic [15:0] rx;
   logic        sclk_q;

   always_ff @(posedge i_clock) begin
      sclk_q <= sclk;
   end

   // count resets while deselected so a stray clock never leaks into a frame
   always_ff @(posedge i_clock) begin
      if (i_rst || select_n_line) begin
         rises <= 5'h00;
      end else if (sclk && !sclk_q) begin
         rises <= rises + 5'h01;
      end
   end

   always_ff @(posedge i_clock) begin
      if (sclk && !sclk_q) begin
         rx <= {rx[14:0], miso};
      end
   end

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst);

   AST_FRAME_LEN: assert property ($rose(select_n_line) |-> rises == 5'h10)
      else $error("frame ended without sixteen clock rises");
   AST_DRIVE_ON: assert property ($fell(select_n_line) |-> ##[1:4] miso_oe)
      else $error("data output not driven after select fell");
   AST_IDLE_CLOCK: assert property (select_n_line |-> !sclk)
      else $error("clock high while deselected");
   AST_ZERO_BIT: assert property ($rose(sclk) && rises == 5'h07 |-> !mosi)
      else $error("eighth command bit not zero");
   AST_MOSI_ON_LOW: assert property ($changed(mosi) |-> !sclk)
      else $error("command line moved while clock high");
   AST_MISO_ON_LOW: assert property (miso_oe && $changed(miso) |-> !sclk)
      else $error("reply line moved while clock high");
   AST_ONE_BIT: assert property ($rose(sclk) && rises == 5'h06 |-> miso)
      else $error("seventh reply bit not one");
   AST_ZERO_FIELD: assert property ($rose(sclk) &&
      rises inside {5'h00, 5'h02, 5'h03, 5'h04, 5'h05} |-> !miso)
      else $error("unused reply bit not zero");
   AST_PARITY: assert property ($rose(select_n_line) && rises == 5'h10 |-> ^rx[8:0])
      else $error("reply parity not odd");
   AST_RELEASE: assert property (select_n_line [*5] |-> !miso_oe)
      else $error("data output still driven while deselected");

   cover property ($rose(select_n_line) && rises == 5'h10);
   cover property ($rose(sclk) && rises == 5'h06 && mosi);
   cover property ($rose(miso_oe));
endmodule
